// ===== rtl/ufnif_map.svh
/*
  Register indices, field limits and reset values of the frame number
  and IN endpoint interrupt flag block.
  Assumes 32-bit classic Wishbone, byte address = 4 x register index.
*/
`ifndef UFNIF_MAP_SVH
`define UFNIF_MAP_SVH
// Endpoint flags: endpoint 0 plus IN endpoints 1..3
`define UFNIF_NUM_EP 4
// Frame number width
`define UFNIF_FRAME_W 11
// Top bit of the low frame byte, first bit of the high part
`define UFNIF_FRAME_LOW_MSB 7
`define UFNIF_FRAME_HIGH_LSB 8
// Wishbone address width and word index slice
`define UFNIF_ADR_W 8
`define UFNIF_IDX_LSB 2
// Register indices
`define UFNIF_IDX_IN_FLAGS 6'h02
`define UFNIF_IDX_IN_ENABLE 6'h07
`define UFNIF_IDX_FRAME_LOW 6'h0c
`define UFNIF_IDX_FRAME_HIGH 6'h0d
// Zero padding above narrow fields
`define UFNIF_PAD_EP 28'h0000000
`define UFNIF_PAD_LOW 24'h000000
`define UFNIF_PAD_HIGH 29'h0000000
// Reset values
`define UFNIF_RST_FRAME 11'h000
`define UFNIF_RST_ENABLE 4'h0
`define UFNIF_RST_DATA 32'h00000000
`endif

// ===== rtl/ufnif_pkg.sv
/*
  Types shared by the frame number and interrupt flag block.
  Assumes ufnif_map.svh on the include path.
*/
`include "ufnif_map.svh"
package ufnif_pkg;
  // Events from the USB engine, same clock
  typedef struct packed {
    logic sof;
    logic [`UFNIF_FRAME_W-1:0] frame;
    logic [`UFNIF_NUM_EP-1:0] ep_done;
  } ufnif_evt_t;
  // State of the top module, except the flag bank held in u_flags
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [`UFNIF_FRAME_W-1:0] frame;
    logic [`UFNIF_NUM_EP-1:0] ien;
    logic irq_req;
    logic irq;
  } ufnif_state_t;
endpackage

// ===== rtl/ufnif_sticky.sv
/*
  Sticky flag bank: bits set by events, whole bank cleared by one strobe.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "ufnif_map.svh"
module ufnif_sticky #(
  parameter int W = `UFNIF_NUM_EP
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] set_bits,
  input wire logic clr,
  output logic [W-1:0] flags
);
  // State of the bank
  typedef struct packed {
    logic [W-1:0] bits;
  } ufnif_sticky_t;
  ufnif_sticky_t st;
  ufnif_sticky_t next_st;

  // Clear first, then set, so an event in the clear cycle survives
  always_comb
  begin
    next_st = st;
    if (clr)
    begin
      next_st.bits = {W{1'b0}};
    end
    next_st.bits = next_st.bits | set_bits;
  end

  // Register the bank
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st <= {W{1'b0}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign flags = st.bits;

  // An event in the clearing cycle stays pending
  a_set_wins_clear:
  assert property (@(posedge clk) disable iff (!nrst)
    (clr && set_bits != {W{1'b0}}) |=>
      ((flags & $past(set_bits)) == $past(set_bits)))
  else $error("event lost in clearing cycle");
endmodule

// ===== rtl/ufnif_top.sv
/*
  Frame number registers and IN endpoint interrupt flags of a USB
  function controller, reached over classic Wishbone (32-bit data).
  Every access is answered one cycle after it is taken.
  Assumes events and the other pending flags come from logic on clk,
  and a master that holds each request until it sees ack.
*/
`timescale 1ns/10ps
`include "ufnif_map.svh"

////////////////////////////////////////////////////////////////////////
// How it works
// - Any pending flag raises the interrupt request
// - Reading flag register returns then clears all but events set in the read cycle
// - Flag writes never set or alter flags
// - Separate enable register, one bit per flag
// - Frame number bits 7..0 at 0x0c
// - Frame bits 10..8 at 0x0d, rest zero
module ufnif_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [`UFNIF_ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire ufnif_pkg::ufnif_evt_t usb_evt,
  input wire logic other_irq_pending,
  output logic usb_irq_req,
  output logic usb_irq
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  // Registered state
  ufnif_pkg::ufnif_state_t st;
  // Next state
  ufnif_pkg::ufnif_state_t next_st;
  // Current pending flags
  logic [`UFNIF_NUM_EP-1:0] flag_q;
  // Request taken this cycle
  logic req;
  // Read and write qualifiers
  logic rd;
  logic wr;
  // Word index of the access
  logic [`UFNIF_ADR_W-`UFNIF_IDX_LSB-1:0] idx;
  // Register hits
  logic hit_flags;
  logic hit_ien;
  logic hit_low;
  logic hit_high;
  // Read of the flag register: clears the bank
  logic rd_flags;
  // Any request source pending
  logic any_pend;
  // Any enabled source pending
  logic any_en_pend;

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  // A request is taken once; ack blocks a second take
  // Without the gate a held request would be taken twice
  assign req = wb_cyc && wb_stb && !st.ack;
  // Direction of the taken request
  assign rd = req && !wb_we;
  assign wr = req && wb_we;
  // Word index from the byte address
  // Low two address bits pick bytes and are ignored
  assign idx = wb_adr[`UFNIF_ADR_W-1:`UFNIF_IDX_LSB];
  // Which register is addressed
  assign hit_flags = (idx == `UFNIF_IDX_IN_FLAGS);
  assign hit_ien = (idx == `UFNIF_IDX_IN_ENABLE);
  assign hit_low = (idx == `UFNIF_IDX_FRAME_LOW);
  assign hit_high = (idx == `UFNIF_IDX_FRAME_HIGH);
  // Read of the flags clears them
  assign rd_flags = rd && hit_flags;

  ////////////////////////////////////////////////////////////////////
  // Pending flags

  // Sticky bank; only engine events set, only a read clears
  // Set wins when an event meets the clearing read
  ufnif_sticky #(
    .W(`UFNIF_NUM_EP)
  ) u_flags (
    .clk(clk),
    .nrst(nrst),
    .set_bits(usb_evt.ep_done),
    .clr(rd_flags),
    .flags(flag_q)
  );

  // Request sources
  assign any_pend = (|flag_q) || other_irq_pending;
  // Enabled sources only
  // Other sources arrive already enabled
  assign any_en_pend = (|(flag_q & st.ien)) || other_irq_pending;

  ////////////////////////////////////////////////////////////////////
  // Next state

  // Bus answer, registers and interrupt outputs
  always_comb
  begin
    next_st = st;
    // One-cycle ack for every taken request
    next_st.ack = req;
    // Read data returns to zero when idle
    // Keeps stale data off the bus
    next_st.dat = `UFNIF_RST_DATA;
    if (rd)
    begin
      // Read mux; unmapped words read zero
      // Hits are exclusive, so order is free
      case (1'b1)
        hit_flags:
        begin
          // Contents before the clear
          next_st.dat = {`UFNIF_PAD_EP, flag_q};
        end
        hit_ien:
        begin
          // Enable bits
          next_st.dat = {`UFNIF_PAD_EP, st.ien};
        end
        hit_low:
        begin
          // Low frame byte
          next_st.dat = {`UFNIF_PAD_LOW,
            st.frame[`UFNIF_FRAME_LOW_MSB:0]};
        end
        hit_high:
        begin
          // High frame bits, upper bits zero
          next_st.dat = {`UFNIF_PAD_HIGH,
            st.frame[`UFNIF_FRAME_W-1:`UFNIF_FRAME_HIGH_LSB]};
        end
        default:
        begin
          // Unmapped word
          next_st.dat = `UFNIF_RST_DATA;
        end
      endcase
    end
    // Only the enable register takes writes; flags ignore them
    if (wr && hit_ien && wb_sel[0])
    begin
      next_st.ien = wb_dat_w[`UFNIF_NUM_EP-1:0];
    end
    // Frame number latched on each start of frame
    // Held unchanged between starts of frame
    if (usb_evt.sof)
    begin
      next_st.frame = usb_evt.frame;
    end
    // Raw request, any flag
    next_st.irq_req = any_pend;
    // Level interrupt, enabled flags only
    next_st.irq = any_en_pend;
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset to defined values
  // Reset branch assigns constants only
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st.ack <= 1'b0;
      st.dat <= `UFNIF_RST_DATA;
      st.frame <= `UFNIF_RST_FRAME;
      st.ien <= `UFNIF_RST_ENABLE;
      st.irq_req <= 1'b0;
      st.irq <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops
  // No gate sits between a flop and its pin

  // Bus answer
  assign wb_ack = st.ack;
  // Read data
  assign wb_dat_r = st.dat;
  // Raw combined request
  assign usb_irq_req = st.irq_req;
  // Enabled interrupt
  assign usb_irq = st.irq;

  ////////////////////////////////////////////////////////////////////
  // Checks

  // Helper: low frame byte
  logic [`UFNIF_FRAME_LOW_MSB:0] frame_lo;
  // Helper: high frame bits
  logic [`UFNIF_FRAME_W-`UFNIF_FRAME_HIGH_LSB-1:0] frame_hi;
  assign frame_lo = st.frame[`UFNIF_FRAME_LOW_MSB:0];
  assign frame_hi = st.frame[`UFNIF_FRAME_W-1:`UFNIF_FRAME_HIGH_LSB];
  // Helper: access hits a mapped word
  logic hit_any;
  assign hit_any = hit_flags || hit_ien || hit_low || hit_high;

  // All checks on clk, off in reset
  // One clock domain, one default clocking
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Request follows the flags one cycle later
  // Skipped while the past cycle was still in reset
  a_irq_req_any:
  assert property ($past(nrst) |->
    usb_irq_req == $past(any_pend))
  else $error("request does not follow flags");

  // Any pending flag raises the request next cycle
  a_irq_req_raw:
  assert property ((flag_q != 4'h0) |=> usb_irq_req)
  else $error("request missing with flag set");

  // Enabled interrupt follows enabled flags
  a_irq_enabled:
  assert property ($past(nrst) |->
    usb_irq == $past(any_en_pend))
  else $error("interrupt does not follow enables");

  // Read returns old contents in the ack cycle
  a_read_returns:
  assert property (rd_flags |=>
    (wb_ack && wb_dat_r == {`UFNIF_PAD_EP, $past(flag_q)}))
  else $error("flag read returns wrong data");

  // After a read only new events remain
  a_read_clears:
  assert property (rd_flags |=> flag_q == $past(usb_evt.ep_done))
  else $error("flag read did not clear");

  // Writes leave the flags alone
  a_write_no_alter:
  assert property ((wr && hit_flags && usb_evt.ep_done == 4'h0) |=>
    flag_q == $past(flag_q))
  else $error("write altered flags");

  // Enable write lands and gates the interrupt
  a_enable_write:
  assert property ((wr && hit_ien && wb_sel[0]) |=>
    (st.ien == $past(wb_dat_w[`UFNIF_NUM_EP-1:0])) ##1
    (usb_irq == $past(any_en_pend)))
  else $error("enable write failed");

  // Enable write without its byte select is ignored
  a_enable_sel_gate:
  assert property ((wr && hit_ien && !wb_sel[0]) |=>
    st.ien == $past(st.ien))
  else $error("enable changed without byte select");

  // Low frame byte read
  a_frame_low_read:
  assert property ((rd && hit_low && !usb_evt.sof) |=>
    wb_dat_r == {`UFNIF_PAD_LOW, frame_lo} ##1 !wb_ack)
  else $error("frame low read wrong");

  // High frame bits read, upper zero
  a_frame_high_read:
  assert property ((rd && hit_high) |=>
    wb_dat_r == {`UFNIF_PAD_HIGH, $past(frame_hi)})
  else $error("frame high read wrong");

  // Start of frame latches the frame number
  a_frame_capture:
  assert property (usb_evt.sof |=>
    st.frame == $past(usb_evt.frame))
  else $error("frame number not latched");

  // Frame number holds between starts of frame
  a_frame_hold:
  assert property (!usb_evt.sof |=>
    st.frame == $past(st.frame))
  else $error("frame number changed without sof");

  // Endpoint event sets its flag and then the request
  a_event_sets_flag:
  assert property ((usb_evt.ep_done != 4'h0) |=>
    ((flag_q & $past(usb_evt.ep_done)) == $past(usb_evt.ep_done))
    ##1 usb_irq_req)
  else $error("event did not set flag");

  // Ack lasts one cycle
  a_ack_single:
  assert property (wb_ack |=> !wb_ack)
  else $error("ack held too long");

  // Ack only answers a request
  a_ack_needs_req:
  assert property (wb_ack |-> $past(wb_cyc && wb_stb))
  else $error("ack without request");

  // Read data is zero outside the ack cycle
  a_idle_data_zero:
  assert property (!wb_ack |-> wb_dat_r == `UFNIF_RST_DATA)
  else $error("read data not zero when idle");

  // Unmapped word is acked and reads zero
  a_unmapped_zero:
  assert property ((rd && !hit_any) |=>
    (wb_ack && wb_dat_r == `UFNIF_RST_DATA))
  else $error("unmapped word read wrong");

  // Flag read with something pending
  c_read_pending:
  cover property (rd_flags && flag_q != 4'h0);

  // Event in the clearing cycle
  c_set_on_clear:
  cover property (rd_flags && usb_evt.ep_done != 4'h0);

  // Frame captured then read high
  c_frame_read:
  cover property (usb_evt.sof ##[1:20] (rd && hit_high));

  // Enabled interrupt raised
  c_irq_raised:
  cover property (!usb_irq ##1 usb_irq);

  // Read of an unmapped word
  c_unmapped_read:
  cover property (rd && !hit_any);

endmodule

// ===== verif/tb.sv
/*
  Self-checking bench: Wishbone master tasks, event driver, integer model.
  Assumes the block answers each request within a few cycles.
*/
`timescale 1ns/10ps
module tb;
  // Bus, event and side inputs
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, other = 0, irq_en = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, d, e, g;
  logic [31:0] dw = 32'h0, rd;
  logic [10:0] f;
  logic [31:0] dr;
  logic ack, req, irq, core_irq;
  ufnif_pkg::ufnif_evt_t evt = '0;
  // Counters and model state
  int failures = 0, checks = 0, m_flags = 0, m_en = 0, r;
  always #20 clk = ~clk;
  ufnif_top u_ufnif_top (.clk(clk), .nrst(nrst), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
    .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack),
    .usb_evt(evt), .other_irq_pending(other), .usb_irq_req(req), .usb_irq(irq));
  ufnif_core_model u_ufnif_core_model (.usb_irq(irq),
    .extended_peripheral_irq_enable(irq_en), .core_irq(core_irq));
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Register value compare
  task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Interrupt line compare
  task cmp_irq(input logic got, input logic exp);
    cmp_reg({31'h0, got}, {31'h0, exp});
  endtask
  // One classic Wishbone cycle, held until ack is seen at a rising edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] dat,
    input logic [3:0] s = 4'h1);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= dat;
    sel <= s;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      failures++;
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Read one register
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    cmp_reg(rd, exp);
  endtask
  // One-cycle event pulse, returns once the request has settled
  task ev(input logic [3:0] done, input logic s, input logic [10:0] fr);
    @(posedge clk);
    evt <= '{sof: s, frame: fr, ep_done: done};
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
    m_flags = m_flags | done;
  endtask
  // Interrupt outputs against the model
  task irq_chk;
    logic x;
    @(negedge clk);
    x = ((m_flags & m_en) != 0) || other;
    cmp_irq(req, (m_flags != 0) || other);
    cmp_irq(irq, x);
    cmp_irq(core_irq, x && irq_en);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    r = $urandom(43);
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values and an unmapped word
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h1c, 32'h0);
    rd_chk(8'h30, 32'h0);
    rd_chk(8'h34, 32'h0);
    rd_chk(8'h3c, 32'h0);
    $display("test reset done");
    // Random events, enables and reads
    for (int i = 0; i < 8; i++)
    begin
      other <= i[0];
      irq_en <= i[1];
      d = 4'($urandom);
      e = 4'($urandom);
      f = 11'($urandom);
      ev(d, 1'b1, f);
      irq_chk();
      wb(1'b1, 8'h1c, {28'h0, e});
      m_en = e;
      irq_chk();
      // Enable write without byte select must not land
      wb(1'b1, 8'h1c, 32'hf, 4'he);
      // Flag read meeting a new event: the event survives
      g = 4'($urandom);
      fork
        rd_chk(8'h08, m_flags);
        ev(g, 1'b0, 11'h0);
      join
      m_flags = g;
      // Write to flags and frame must change nothing
      wb(1'b1, 8'h08, 32'hffffffff);
      wb(1'b1, 8'h30, 32'hffffffff);
      ev(4'h0, 1'b0, ~f);
      rd_chk(8'h08, m_flags);
      m_flags = 0;
      irq_chk();
      rd_chk(8'h08, 32'h0);
      rd_chk(8'h30, {24'h0, f[7:0]});
      rd_chk(8'h34, {29'h0, f[10:8]});
      rd_chk(8'h1c, {28'h0, e});
      $display("test event round %0d done", i);
    end
    // Reset in mid-run clears enables and frame
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(8'h1c, 32'h0);
    rd_chk(8'h34, 32'h0);
    $display("test second reset done");
    summarize();
  end
  // Watchdog against a hung handshake
  initial
  begin
    #400000;
    failures++;
    summarize();
  end
endmodule

// ===== verif/ufnif_core_model.sv
/*
  Processor side of the USB interrupt: gates the combined request.
  Assumes a level request from the USB block on the same clock.
*/
`timescale 1ns/10ps
module ufnif_core_model (
  input wire logic usb_irq,
  input wire logic extended_peripheral_irq_enable,
  output logic core_irq
);
  // Core sees the request only while enabled
  assign core_irq = usb_irq & extended_peripheral_irq_enable;
endmodule
